// *** core/lcm_pkg.sv ***
package lcm_pkg;
   // ==========================================
   // register indices and byte addresses (byte address is four times the index)
   localparam logic [11:0] IDX_IND_SEL = 12'h0452;
   localparam logic [11:0] IDX_CLK_SEL = 12'h0453;
   localparam logic [11:0] IDX_FORCE_LO = 12'h0454;
   localparam logic [11:0] IDX_OVR_CTL = 12'h0455;
   localparam logic [13:0] ADDR_IND_SEL = {IDX_IND_SEL, 2'b00};
   localparam logic [13:0] ADDR_CLK_SEL = {IDX_CLK_SEL, 2'b00};
   localparam logic [13:0] ADDR_FORCE_LO = {IDX_FORCE_LO, 2'b00};
   localparam logic [13:0] ADDR_OVR_CTL = {IDX_OVR_CTL, 2'b00};
   // ==========================================
   // field positions
   localparam int IND0_SEL_LSB = 0;
   localparam int IND1_SEL_LSB = 8;
   localparam int COMPL_SEL_LSB = 9;
   localparam int CLK_SRC_LSB = 3;
   localparam int CLK_PIN_SEL_LSB = 0;
   localparam int OVR_EN_BIT = 4;
   localparam int OVR_DIR_BIT = 5;
   // ==========================================
   // reset values
   localparam logic [15:0] RST_IND_SEL = 16'h0000;
   localparam logic [15:0] RST_CLK_SEL = 16'h0001;
   localparam logic [15:0] RST_FORCE_LO = 16'h0000;
   localparam logic [15:0] RST_OVR_CTL = 16'h0000;
   // writable masks
   localparam logic [15:0] MASK_IND_SEL = 16'h0707;
   localparam logic [15:0] MASK_CLK_SEL = 16'h003F;
   localparam logic [15:0] MASK_FORCE_LO = 16'hFFCF;
   localparam logic [15:0] MASK_OVR_CTL = 16'h0030;
   localparam logic [15:0] MASK_COMPL = 16'h0E00;
   localparam logic [13:0] ADDR_COMPL = 14'h0010;
   // ==========================================
   // indicator / data pin select codes
   localparam logic [2:0] SEL_FUNC = 3'h0;
   localparam logic [2:0] SEL_CLOCK = 3'h1;
   localparam logic [2:0] SEL_MATCH = 3'h2;
   localparam logic [2:0] SEL_UVOLT = 3'h3;
   localparam logic [2:0] SEL_IRQ = 3'h4;
   localparam logic [2:0] SEL_COMPL = 3'h5;
   localparam logic [2:0] SEL_LOW = 3'h6;
   localparam logic [2:0] SEL_HIGH = 3'h7;
   // clock source codes
   localparam logic [2:0] SRC_XTAL = 3'h0;
   localparam logic [2:0] SRC_FAST_A = 3'h3;
   localparam logic [2:0] SRC_FAST_B = 3'h4;
   // pad count
   localparam int NUM_PADS = 16;
endpackage : lcm_pkg

// *** core/lcm_sel8.sv ***
`timescale 1ns/100ps
// ==========================================
// eight-way one-bit selector, registered output
module lcm_sel8 (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_sel,
   input wire logic [7:0] i_src,
   output logic o_q
);
   typedef struct packed {
      logic q;
   } lcm_sel_state_t;
   lcm_sel_state_t st_r;
   lcm_sel_state_t st_nxt;

   // pick one source
   always_comb begin
      st_nxt = st_r;
      st_nxt.q = i_src[i_sel];
   end

   // register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_q = st_r.q;
endmodule : lcm_sel8

// *** core/lcm_top.sv ***
`timescale 1ns/100ps
module lcm_top
   import lcm_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   // AXI4-Lite slave
   input wire logic [13:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [13:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // functional sources (device clock domain)
   input wire logic I_IND0_FUNC,
   input wire logic I_IND1_FUNC,
   input wire logic I_IND2_FUNC,
   input wire logic I_DATA_MATCH,
   input wire logic I_UNDER_VOLT,
   input wire logic I_IRQ,
   input wire logic [5:0] I_COMPL,
   input wire logic I_CLK_XTAL,
   input wire logic I_CLK_FAST,
   // normal pad function values and enables for pads 3 and 6..15
   input wire logic [NUM_PADS-1:0] I_PAD_FUNC_O,
   input wire logic [NUM_PADS-1:0] I_PAD_FUNC_OE,
   // pad outputs
   output logic [NUM_PADS-1:0] O_PAD_O,
   output logic [NUM_PADS-1:0] O_PAD_OE
);
   // ==========================================
   // state
   typedef struct packed {
      logic [15:0] ind_sel;
      logic [15:0] clk_sel;
      logic [15:0] force_lo;
      logic [15:0] ovr_ctl;
      logic [15:0] compl;
      logic aw_got;
      logic w_got;
      logic [13:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [NUM_PADS-1:0] pad_o;
      logic [NUM_PADS-1:0] pad_oe;
   } lcm_state_t;
   lcm_state_t st_r;
   lcm_state_t st_nxt;

   logic ind0_q;
   logic ind1_q;
   logic clkp_q;
   logic compl_bit;
   logic clk_src;
   logic [15:0] wr_val;
   logic [15:0] rd_val;
   logic rd_hit;
   logic wr_hit;

   // ==========================================
   // source selection
   always_comb begin
      // reserved compliance codes give low
      compl_bit = 1'b0;
      if (st_r.compl[COMPL_SEL_LSB +: 3] <= 3'h5) begin
         compl_bit = I_COMPL[st_r.compl[COMPL_SEL_LSB +: 3]];
      end
      // clock source; reserved codes low
      unique case (st_r.clk_sel[CLK_SRC_LSB +: 3])
         SRC_XTAL: clk_src = I_CLK_XTAL;
         SRC_FAST_A, SRC_FAST_B: clk_src = I_CLK_FAST;
         default: clk_src = 1'b0;
      endcase
   end

   // first indicator pin
   lcm_sel8 u_ind0 (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_sel(st_r.ind_sel[IND0_SEL_LSB +: 3]),
      .i_src({1'b1, 1'b0, compl_bit, I_IRQ, I_UNDER_VOLT, I_DATA_MATCH, 1'b0, I_IND0_FUNC}),
      .o_q(ind0_q)
   );
   // second indicator pin
   lcm_sel8 u_ind1 (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_sel(st_r.ind_sel[IND1_SEL_LSB +: 3]),
      .i_src({1'b1, 1'b0, I_COMPL[0], I_IRQ, I_UNDER_VOLT, I_DATA_MATCH, 1'b0, I_IND1_FUNC}),
      .o_q(ind1_q)
   );
   // clock-out pin; 100/101 low, 110 reserved low
   lcm_sel8 u_clkp (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_sel(st_r.clk_sel[CLK_PIN_SEL_LSB +: 3]),
      .i_src({1'b1, 1'b0, 1'b0, 1'b0, I_UNDER_VOLT, I_DATA_MATCH, clk_src, I_IND2_FUNC}),
      .o_q(clkp_q)
   );

   // ==========================================
   // register read/write decode
   always_comb begin
      wr_val = st_r.wdata[15:0];
      wr_hit = 1'b1;
      unique case (st_r.awaddr)
         ADDR_IND_SEL, ADDR_CLK_SEL, ADDR_FORCE_LO, ADDR_OVR_CTL, ADDR_COMPL: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
      rd_hit = 1'b1;
      unique case (I_ARADDR)
         ADDR_IND_SEL: rd_val = st_r.ind_sel;
         ADDR_CLK_SEL: rd_val = st_r.clk_sel;
         ADDR_FORCE_LO: rd_val = st_r.force_lo;
         ADDR_OVR_CTL: rd_val = st_r.ovr_ctl;
         ADDR_COMPL: rd_val = st_r.compl;
         default: begin
            rd_val = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ==========================================
   // next state
   always_comb begin
      st_nxt = st_r;
      // write channel capture
      if (I_AWVALID && !st_r.aw_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = {I_AWADDR[13:2], 2'b00};
      end
      if (I_WVALID && !st_r.w_got && !st_r.bvalid) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = I_WDATA;
         st_nxt.wstrb = I_WSTRB;
      end
      // commit write; reserved bits masked
      if (st_r.aw_got && st_r.w_got) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wr_hit ? 2'b00 : 2'b10;
         for (int b = 0; b < 2; b++) begin
            if (st_r.wstrb[b]) begin
               unique case (st_r.awaddr)
                  ADDR_IND_SEL: st_nxt.ind_sel[b*8 +: 8] = wr_val[b*8 +: 8] & MASK_IND_SEL[b*8 +: 8];
                  ADDR_CLK_SEL: st_nxt.clk_sel[b*8 +: 8] = wr_val[b*8 +: 8] & MASK_CLK_SEL[b*8 +: 8];
                  ADDR_FORCE_LO: st_nxt.force_lo[b*8 +: 8] = wr_val[b*8 +: 8] & MASK_FORCE_LO[b*8 +: 8];
                  ADDR_OVR_CTL: st_nxt.ovr_ctl[b*8 +: 8] = wr_val[b*8 +: 8] & MASK_OVR_CTL[b*8 +: 8];
                  ADDR_COMPL: st_nxt.compl[b*8 +: 8] = wr_val[b*8 +: 8] & MASK_COMPL[b*8 +: 8];
                  default: ;
               endcase
            end
         end
      end
      if (st_r.bvalid && I_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end
      // read
      if (I_ARVALID && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = {16'h0000, rd_val};
         st_nxt.rresp = rd_hit ? 2'b00 : 2'b10;
      end else if (st_r.rvalid && I_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
      // pad outputs: functional, then override
      st_nxt.pad_o = I_PAD_FUNC_O;
      st_nxt.pad_oe = I_PAD_FUNC_OE;
      st_nxt.pad_o[0] = ind0_q;
      st_nxt.pad_o[1] = ind1_q;
      st_nxt.pad_o[2] = clkp_q;
      st_nxt.pad_oe[2:0] = 3'h7;
      if (st_r.ovr_ctl[OVR_EN_BIT]) begin
         st_nxt.pad_oe = {NUM_PADS{~st_r.ovr_ctl[OVR_DIR_BIT]}};
         st_nxt.pad_o = st_r.force_lo;
      end
      st_nxt.pad_o[5:4] = 2'b00; // reserved pads
      st_nxt.pad_oe[5:4] = 2'b00;
   end

   // ==========================================
   // state register
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_r <= '0;
         st_r.ind_sel <= RST_IND_SEL;
         st_r.clk_sel <= RST_CLK_SEL;
         st_r.force_lo <= RST_FORCE_LO;
         st_r.ovr_ctl <= RST_OVR_CTL;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // outputs
   assign O_AWREADY = !st_r.aw_got && !st_r.bvalid;
   assign O_WREADY = !st_r.w_got && !st_r.bvalid;
   assign O_BVALID = st_r.bvalid;
   assign O_BRESP = st_r.bresp;
   assign O_ARREADY = !st_r.rvalid;
   assign O_RVALID = st_r.rvalid;
   assign O_RDATA = st_r.rdata;
   assign O_RRESP = st_r.rresp;
   assign O_PAD_O = st_r.pad_o;
   assign O_PAD_OE = st_r.pad_oe;
endmodule : lcm_top

// *** tb/lcm_asserts.sv ***
`timescale 1ns/100ps
// ==========================================
// register bus and reserved pad checks at the top ports
module lcm_asserts (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic [1:0] O_BRESP,
   input wire logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic [15:0] O_PAD_O,
   input wire logic [15:0] O_PAD_OE
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped early");
   AST_R_UPPER: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0000)
      else $error("upper read half not zero");
   AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
      else $error("read address taken while busy");
   AST_AW_BLOCK: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
      else $error("write taken while response pending");
   AST_R_LAT: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
      else $error("read answer late");
   AST_B_LAT: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID)
      else $error("write answer late");
   AST_B_CODE: assert property (O_BVALID |-> O_BRESP[0] == 1'b0)
      else $error("bad write response code");
   AST_B_DROP: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
      else $error("write response not cleared after acceptance");
   AST_R_DROP: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
      else $error("read data not cleared after acceptance");
   AST_PAD_RSV: assert property (O_PAD_O[5:4] == 2'b00 && O_PAD_OE[5:4] == 2'b00)
      else $error("reserved pads driven");
endmodule : lcm_asserts

bind lcm_top lcm_asserts u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_AWVALID(I_AWVALID),
   .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
   .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
   .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_PAD_O(O_PAD_O),
   .O_PAD_OE(O_PAD_OE));

// *** tb/lcm_board.sv ***
`timescale 1ns/100ps
// ==========================================
// board side sources feeding the pin muxes
module lcm_board (
   input wire logic [15:0] i_pat,
   output logic [15:0] o_src
);
   // indicator, indication, compliance and clock levels held per test
   assign o_src = i_pat;
endmodule : lcm_board

// *** tb/tb.sv ***
`timescale 1ns/100ps
// ==========================================
// pin mux, pad override and register bench
module tb;
   import lcm_pkg::*;
   localparam logic [13:0] AD [4] = '{ADDR_IND_SEL, ADDR_CLK_SEL, ADDR_FORCE_LO, ADDR_OVR_CTL};
   localparam logic [15:0] RV [4] = '{RST_IND_SEL, RST_CLK_SEL, RST_FORCE_LO, RST_OVR_CTL};
   localparam logic [15:0] MK [4] = '{MASK_IND_SEL, MASK_CLK_SEL, MASK_FORCE_LO, MASK_OVR_CTL};
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [13:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [15:0] pat = 0, fo = 0, foe = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] src, pad_o, pad_oe;
   logic [33:0] q [$];
   logic [1:0] bq [$];
   int num_errors = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   lcm_board u_brd (.i_pat(pat), .o_src(src));
   lcm_top u_dut (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'h3), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_IND0_FUNC(src[0]),
      .I_IND1_FUNC(src[1]), .I_IND2_FUNC(src[2]), .I_DATA_MATCH(src[3]),
      .I_UNDER_VOLT(src[4]), .I_IRQ(src[5]), .I_COMPL(src[11:6]), .I_CLK_XTAL(src[12]),
      .I_CLK_FAST(src[13]), .I_PAD_FUNC_O(fo), .I_PAD_FUNC_OE(foe), .O_PAD_O(pad_o),
      .O_PAD_OE(pad_oe));
   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic chk_pad(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pad
   task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_b
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      logic aw, w, b;
      bq.push_back((a inside {AD[0], AD[1], AD[2], AD[3], ADDR_COMPL}) ? 2'b00 : 2'b10);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [13:0] a, input logic [1:0] r, input logic [15:0] d);
      logic ar, v;
      q.push_back({r, 16'h0000, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ar = arvalid && arready;
         v = rvalid;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end while (!v);
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : settle
   function automatic logic pin(input logic [2:0] c, input logic fn, input logic [15:0] p);
      case (c)
         3'h0: return fn;
         3'h2: return p[3];
         3'h3: return p[4];
         3'h4: return p[5];
         3'h5: return p[6];
         3'h7: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : pin
   function automatic logic ck(input logic [2:0] c, input logic [2:0] s, input logic [15:0] p);
      case (c)
         3'h1: return (s == 3'h0) ? p[12] : (s == 3'h3 || s == 3'h4) && p[13];
         3'h4, 3'h5: return 1'b0;
         default: return pin(c, p[2], p);
      endcase
   endfunction : ck
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // bus answers against the oldest note
   always @(posedge clk) begin
      if (rvalid && rready) chk_rd({rresp, rdata}, q.pop_front());
      if (bvalid && bready) chk_b(bresp, bq.pop_front());
   end
   // hang guard
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      summarize();
   end
   // main sequence
   initial begin
      logic [2:0] c;
      logic [15:0] f;
      void'($urandom(32'he9e4));
      fo <= 16'($urandom);
      foe <= 16'($urandom);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(AD[i], 2'b00, RV[i]);
         wr(AD[i], 16'hFFFF);
         rd(AD[i], 2'b00, MK[i]);
         wr(AD[i], RV[i]);
      end
      wr(14'h0020, 16'hFFFF);
      rd(14'h0020, 2'b10, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         c = i[3] ? 3'h1 : i[2:0];
         pat <= 16'($urandom);
         wr(ADDR_IND_SEL, {5'h00, c, 5'h00, c});
         wr(ADDR_CLK_SEL, {10'h000, i[2:0], c});
         settle();
         chk_pad({13'h0000, pad_o[2:0]}, {13'h0000, ck(c, i[2:0], pat), pin(c, pat[1], pat), pin(c, pat[0], pat)});
         @(posedge clk);
      end
      wr(ADDR_IND_SEL, 16'h0005);
      for (int i = 0; i < 6; i++) begin
         pat <= 16'($urandom);
         wr(ADDR_COMPL, {4'h0, i[2:0], 9'h000});
         settle();
         chk_pad({15'h0000, pad_o[0]}, {15'h0000, pat[6 + i]});
         @(posedge clk);
      end
      f = 16'($urandom);
      wr(ADDR_FORCE_LO, f);
      wr(ADDR_OVR_CTL, 16'h0010);
      settle();
      chk_pad(pad_o, f & MASK_FORCE_LO);
      chk_pad(pad_oe, MASK_FORCE_LO);
      @(posedge clk);
      wr(ADDR_OVR_CTL, 16'h0030);
      settle();
      chk_pad(pad_oe, 16'h0000);
      @(posedge clk);
      wr(ADDR_OVR_CTL, 16'h0000);
      settle();
      chk_pad(pad_oe, (foe & 16'hFFC8) | 16'h0007);
      chk_pad(pad_o & 16'hFFC8, fo & 16'hFFC8);
      @(posedge clk);
      // mid-run reset brings IND_SEL, CLK_SEL, FORCE_LO and OVR_CTL back
      wr(ADDR_IND_SEL, 16'h0707);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(AD[i], 2'b00, RV[i]);
      end
      summarize();
   end
endmodule : tb
